// ---- ncp_pkg.sv ----
/*
 * Package for the host-side NAND command/address port controller:
 * register map, field positions, command codes, pin timing and carriers.
 * Assumes a single 40 MHz clock; every time below is turned into cycles here.
 */
`default_nettype none
package ncp_pkg;
    // Clock and pin timing, in ns as printed
    localparam int CLK_PERIOD_NS = 25;
    localparam int T_WP_NS = 12;          // Write strobe low width
    localparam int T_CLS_NS = 12;         // Latch select and data setup
    localparam int T_WH_NS = 10;          // Strobe high hold
    localparam int T_REA_NS = 20;         // Read strobe access time
    localparam int T_WHR_NS = 60;         // Write strobe high to read strobe low
    localparam int T_WB_NS = 100;         // Write strobe high to busy, a longest time
    localparam int SYNC_STAGES = 2;       // Flops on every pin input

    // Least time in whole cycles, never below one
    function automatic int cyc_min(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam logic [3:0] SETUP_CYC = 4'(cyc_min(T_CLS_NS));
    localparam logic [3:0] WE_LOW_CYC = 4'(cyc_min(T_WP_NS));
    localparam logic [3:0] HIGH_CYC = 4'(cyc_min(T_WH_NS));
    localparam logic [3:0] RD_SETUP_CYC = 4'(cyc_min(T_WHR_NS));
    localparam logic [3:0] RE_LOW_CYC = 4'(cyc_min(T_REA_NS) + SYNC_STAGES);
    // Busy may appear as late as tWB, so the wait is rounded up to cover it
    localparam logic [3:0] WB_CYC = 4'(cyc_min(T_WB_NS) + SYNC_STAGES);

    // Array geometry
    localparam logic [12:0] PAGE_BYTES = 13'd4224;
    localparam int MAIN_BYTES = 4096;
    localparam int SPARE_BYTES = 128;
    localparam int PAGES_PER_BLOCK = 64;
    localparam int BLOCK_LSB = 6;

    // Command codes
    localparam logic [7:0] CMD_READ_SETUP = 8'h00;
    localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
    localparam logic [7:0] CMD_COL_OUT = 8'h05;
    localparam logic [7:0] CMD_COL_OUT_CONFIRM = 8'hE0;
    localparam logic [7:0] CMD_DATA_IN = 8'h80;
    localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
    localparam logic [7:0] CMD_COL_IN = 8'h85;
    localparam logic [7:0] CMD_MULTI_FIRST = 8'h11;
    localparam logic [7:0] CMD_MULTI_SECOND = 8'h81;
    localparam logic [7:0] CMD_COPYBACK_READ = 8'h35;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
    localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_ID_READ = 8'h90;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_STATUS_MULTI = 8'h71;
    localparam logic [7:0] CMD_ECC_STATUS = 8'h7A;
    localparam logic [7:0] CMD_RESET = 8'hFF;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_COLUMN = 8'h04;
    localparam logic [7:0] REG_PAGE = 8'h08;
    localparam logic [7:0] REG_OP = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_INFO = 8'h14;

    // Field positions
    localparam int CTRL_SEL_BIT = 0;
    localparam int CTRL_WPN_BIT = 1;
    localparam int OP_KIND_LSB = 8;
    localparam int STAT_ENGINE_BIT = 0;
    localparam int STAT_READY_BIT = 1;
    localparam int STAT_REFUSED_BIT = 2;
    localparam int STAT_MFAIL_BIT = 3;
    localparam int STAT_BYTE_LSB = 8;
    localparam int STAT_CMD_LSB = 16;
    localparam int INFO_PAGE_LSB = 16;
    localparam int MSTAT_FAIL_BIT = 0;

    // Reset values
    localparam logic CTRL_SEL_RESET = 1'b0;
    localparam logic CTRL_WPN_RESET = 1'b0;

    typedef enum logic [2:0] {
        NCP_K_CMD = 3'b000, NCP_K_ADDR5 = 3'b001, NCP_K_ADDR2 = 3'b010, NCP_K_ADDR3 = 3'b011,
        NCP_K_ADDR1 = 3'b100, NCP_K_WRITE = 3'b101, NCP_K_READ = 3'b110
    } ncp_kind_t;

    typedef enum logic [2:0] {
        NCP_ST_IDLE = 3'b000, NCP_ST_SETUP = 3'b001, NCP_ST_LOW = 3'b010,
        NCP_ST_HIGH = 3'b011, NCP_ST_WBUSY = 3'b100, NCP_ST_WRDY = 3'b101
    } ncp_st_t;

    typedef struct packed {
        logic cle;
        logic ale;
        logic ce_n;
        logic we_n;
        logic read_strobe_n;
        logic wp_n;
        logic [7:0] byte_port_out;
        logic byte_port_oe;
    } ncp_pin_out_t;

    typedef struct packed {
        logic ready_busy_n;
        logic [7:0] byte_port_in;
    } ncp_pin_in_t;
endpackage
`default_nettype wire

// ---- ncp_host.sv ----
/*
 * Host controller for a NAND command/address/data port, driven by software
 * over AHB-Lite. Each accepted write to the operation register plays one command,
 * an address group, or one data byte on the pins.
 * Assumes hclk at 40 MHz, the ready/busy line pulled up outside, and pin
 * inputs asynchronous to hclk.
 */
// The AHB-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module ncp_host
    import ncp_pkg::*;
(
    // Clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hclk_en,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // NAND pins
    input wire ncp_pin_in_t pin_in,
    output var ncp_pin_out_t pin_out
);

    // Whole state of the controller
    typedef struct packed {
        ncp_st_t st;              // Pin sequencer state
        logic [3:0] cnt;          // Cycles left in the current phase
        logic [2:0] cyc;          // Address cycle number, 0 to 4
        ncp_kind_t kind;          // Operation being played
        logic [7:0] op_byte;      // Command or data byte
        logic sel;                // Chip select wanted by software
        logic wpn;                // Write protect level wanted
        logic [12:0] col;         // Column, mirrors device counter on reads, not on data writes
        logic [17:0] page;        // Page address
        logic [7:0] last_cmd;     // Last command sent
        logic [7:0] rd_byte;      // Last byte read
        logic refused;            // Last operation request refused
        logic ph_valid;           // AHB data phase pending
        logic ph_write;
        logic [7:0] ph_addr;
        logic [31:0] hrdata;
        logic hreadyout;
        logic rb_s1;              // Ready/busy synchroniser
        logic rb_s2;
        logic [7:0] dq_s1;        // Port input synchroniser
        logic [7:0] dq_s2;
        ncp_pin_out_t pins;
    } ncp_state_t;

    ncp_state_t q;
    ncp_state_t next_q;

    // Byte sent in a given address cycle
    function automatic logic [7:0] addr_byte(input logic [2:0] c, input logic [12:0] col,
                                             input logic [17:0] pg);
        case (c)
            3'h0: addr_byte = col[7:0];
            3'h1: addr_byte = {3'h0, col[12:8]};
            3'h2: addr_byte = pg[7:0];
            3'h3: addr_byte = pg[15:8];
            3'h4: addr_byte = {6'h00, pg[17:16]};
            default: addr_byte = 8'h00;
        endcase
    endfunction

    // Commands that the device still takes while busy
    function automatic logic busy_ok(input logic [7:0] b);
        busy_ok = (b == CMD_STATUS) || (b == CMD_STATUS_MULTI) || (b == CMD_RESET);
    endfunction

    // Commands after which the device goes busy
    function automatic logic starts_busy(input logic [7:0] b);
        starts_busy = (b == CMD_READ_CONFIRM) || (b == CMD_COPYBACK_READ) || (b == CMD_PROG_CONFIRM)
            || (b == CMD_MULTI_FIRST) || (b == CMD_ERASE_CONFIRM) || (b == CMD_RESET);
    endfunction

    // First address cycle of each address kind
    function automatic logic [2:0] first_cyc(input ncp_kind_t k);
        first_cyc = (k == NCP_K_ADDR3) ? 3'h2 : 3'h0;
    endfunction

    // Last address cycle of each address kind
    function automatic logic [2:0] last_cyc(input ncp_kind_t k);
        case (k)
            NCP_K_ADDR5: last_cyc = 3'h4;
            NCP_K_ADDR3: last_cyc = 3'h4;
            NCP_K_ADDR2: last_cyc = 3'h1;
            default: last_cyc = 3'h0;
        endcase
    endfunction

    logic is_addr;       // Current kind is an address group
    logic is_rd;         // Current kind reads the port
    logic req_go;        // Software asked for an operation
    logic req_ok;        // Request passes all checks
    ncp_kind_t req_kind;
    logic [7:0] req_byte;
    logic [7:0] cur_byte;
    logic [31:0] rd_val;
    logic dev_busy;

    // Next state
    always_comb begin
        next_q = q;
        is_addr = (q.kind == NCP_K_ADDR5) || (q.kind == NCP_K_ADDR2) || (q.kind == NCP_K_ADDR3);
        is_rd = (q.kind == NCP_K_READ);
        dev_busy = !q.rb_s2;
        req_kind = ncp_kind_t'(hwdata[OP_KIND_LSB +: 3]);
        req_byte = hwdata[7:0];
        req_go = q.ph_valid && q.ph_write && (q.ph_addr == REG_OP);
        cur_byte = (q.kind == NCP_K_ADDR1) ? q.op_byte : addr_byte(q.cyc, q.col, q.page);
        if (!is_addr && q.kind != NCP_K_ADDR1) begin
            cur_byte = q.op_byte;
        end

        // Pin synchronisers, two flops each
        next_q.rb_s1 = pin_in.ready_busy_n;
        next_q.rb_s2 = q.rb_s1;
        next_q.dq_s1 = pin_in.byte_port_in;
        next_q.dq_s2 = q.dq_s1;

        // Request checks before anything reaches the pins
        req_ok = (q.st == NCP_ST_IDLE) && q.sel;
        if (dev_busy) begin
            // Busy: status and reset only, or reading the status byte
            if (req_kind == NCP_K_CMD) begin
                req_ok = req_ok && busy_ok(req_byte);
            end else if (req_kind == NCP_K_READ) begin
                req_ok = req_ok && (q.last_cmd == CMD_STATUS || q.last_cmd == CMD_STATUS_MULTI);
            end else begin
                req_ok = 1'b0;
            end
        end
        if (req_kind == NCP_K_WRITE && !q.wpn) begin
            req_ok = 1'b0;
        end
        if (q.col >= PAGE_BYTES && (req_kind == NCP_K_ADDR5 || req_kind == NCP_K_ADDR2)) begin
            req_ok = 1'b0;
        end
        if (req_kind > NCP_K_READ) begin
            req_ok = 1'b0;
        end

        // Register writes in the AHB data phase
        if (q.ph_valid && q.ph_write) begin
            case (q.ph_addr)
                REG_CTRL: begin
                    // Dropping select while busy has no effect on the device
                    next_q.sel = hwdata[CTRL_SEL_BIT];
                    next_q.wpn = hwdata[CTRL_WPN_BIT];
                end
                REG_COLUMN: next_q.col = hwdata[12:0];
                REG_PAGE: next_q.page = hwdata[17:0];
                REG_OP: begin
                    next_q.refused = !req_ok;
                    if (req_ok) begin
                        next_q.kind = req_kind;
                        next_q.op_byte = req_byte;
                        next_q.cyc = first_cyc(req_kind);
                        next_q.st = NCP_ST_SETUP;
                        // Reads wait out the write-to-read gap; the first setup edge
                        // only puts the pins out, so the strobe never moves with them
                        next_q.cnt = (req_kind == NCP_K_READ) ? RD_SETUP_CYC : SETUP_CYC;
                    end
                end
                default: begin
                    // Unmapped or read-only: ignored
                end
            endcase
        end
        next_q.pins.ce_n = !next_q.sel;
        next_q.pins.wp_n = next_q.wpn;

        // Pin sequencer
        case (q.st)
            NCP_ST_IDLE: begin
                next_q.pins.we_n = 1'b1;
                next_q.pins.read_strobe_n = 1'b1;
                next_q.pins.byte_port_oe = 1'b0;
            end
            NCP_ST_SETUP: begin
                // Latch selects and data settle with strobes high
                next_q.pins.cle = (q.kind == NCP_K_CMD);
                next_q.pins.ale = is_addr || (q.kind == NCP_K_ADDR1);
                next_q.pins.byte_port_out = cur_byte;
                next_q.pins.byte_port_oe = !is_rd;
                if (q.cnt != 4'h0) begin
                    next_q.cnt = q.cnt - 4'h1;
                end else begin
                    next_q.st = NCP_ST_LOW;
                    if (is_rd) begin
                        next_q.pins.read_strobe_n = 1'b0;
                        next_q.col = q.col + 13'h1;
                        next_q.cnt = RE_LOW_CYC - 4'h1;
                    end else begin
                        next_q.pins.we_n = 1'b0;
                        next_q.cnt = WE_LOW_CYC - 4'h1;
                    end
                end
            end
            NCP_ST_LOW: begin
                if (q.cnt != 4'h0) begin
                    next_q.cnt = q.cnt - 4'h1;
                end else begin
                    // Rising strobe: device latches, or the read byte is in
                    next_q.pins.we_n = 1'b1;
                    next_q.pins.read_strobe_n = 1'b1;
                    if (is_rd) begin
                        next_q.rd_byte = q.dq_s2;
                    end
                    if (q.kind == NCP_K_CMD) begin
                        next_q.last_cmd = q.op_byte;
                    end
                    next_q.st = NCP_ST_HIGH;
                    next_q.cnt = HIGH_CYC - 4'h1;
                end
            end
            NCP_ST_HIGH: begin
                if (q.cnt != 4'h0) begin
                    next_q.cnt = q.cnt - 4'h1;
                end else if (is_addr && q.cyc != last_cyc(q.kind)) begin
                    // Next cycle of the address group
                    next_q.cyc = q.cyc + 3'h1;
                    next_q.st = NCP_ST_SETUP;
                    // New byte settles a full cycle before the strobe falls
                    next_q.cnt = SETUP_CYC;
                end else if (q.kind == NCP_K_CMD && starts_busy(q.op_byte)) begin
                    next_q.st = NCP_ST_WBUSY;
                    next_q.cnt = WB_CYC - 4'h1;
                end else begin
                    next_q.st = NCP_ST_IDLE;
                    next_q.pins.cle = 1'b0;
                    next_q.pins.ale = 1'b0;
                    next_q.pins.byte_port_oe = 1'b0;
                end
            end
            NCP_ST_WBUSY: begin
                // Busy may not show yet; do not trust ready too early
                next_q.pins.cle = 1'b0;
                next_q.pins.byte_port_oe = 1'b0;
                if (q.cnt != 4'h0) begin
                    next_q.cnt = q.cnt - 4'h1;
                end else begin
                    next_q.st = NCP_ST_WRDY;
                end
            end
            NCP_ST_WRDY: begin
                // Strobes stay high until ready is back
                if (q.rb_s2) begin
                    next_q.st = NCP_ST_IDLE;
                end
            end
            default: next_q.st = NCP_ST_IDLE;
        endcase

        // AHB address phase; read data prepared for the data phase
        rd_val = 32'h0000_0000;
        case (haddr[7:0])
            REG_CTRL: rd_val = {30'h0, q.wpn, q.sel};
            REG_COLUMN: rd_val = {19'h0, q.col};
            REG_PAGE: rd_val = {14'h0, q.page};
            REG_OP: rd_val = {21'h0, q.kind, q.op_byte};
            REG_STATUS: begin
                rd_val[STAT_ENGINE_BIT] = (q.st != NCP_ST_IDLE);
                rd_val[STAT_READY_BIT] = q.rb_s2;
                rd_val[STAT_REFUSED_BIT] = q.refused;
                rd_val[STAT_MFAIL_BIT] = (q.last_cmd == CMD_STATUS_MULTI) && q.rd_byte[MSTAT_FAIL_BIT];
                rd_val[STAT_BYTE_LSB +: 8] = q.rd_byte;
                rd_val[STAT_CMD_LSB +: 8] = q.last_cmd;
            end
            REG_INFO: rd_val = {10'h0, q.page[BLOCK_LSB - 1:0], 4'h0, q.page[17:BLOCK_LSB]};
            default: rd_val = 32'h0000_0000;
        endcase
        next_q.ph_valid = hsel && hready && htrans[1];
        next_q.ph_write = hwrite;
        next_q.ph_addr = {haddr[7:2], 2'b00};
        if (hsel && hready && htrans[1] && !hwrite) begin
            next_q.hrdata = rd_val;
        end
        next_q.hreadyout = 1'b1;
    end

    // State register, frozen while the enable is low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
            q.st <= NCP_ST_IDLE;
            q.kind <= NCP_K_CMD;
            q.sel <= CTRL_SEL_RESET;
            q.wpn <= CTRL_WPN_RESET;
            q.last_cmd <= CMD_READ_SETUP;
            q.pins.ce_n <= 1'b1;
            q.pins.we_n <= 1'b1;
            q.pins.read_strobe_n <= 1'b1;
        end else if (hclk_en) begin
            q <= next_q;
        end
    end

    // Outputs straight from flops, hresp tied low
    assign pin_out = q.pins;
    assign hrdata = q.hrdata;
    assign hreadyout = q.hreadyout;
    assign hresp = 1'b0;

    // Checks on the pin sequence
    property p_latch_excl;
        @(posedge hclk) disable iff (!hresetn || !hclk_en) !(q.pins.cle && q.pins.ale);
    endproperty
    a_latch_excl: assert property (p_latch_excl) else $error("Both latch selects high");

    property p_busy_strobe;
        @(posedge hclk) disable iff (!hresetn || !hclk_en)
            $fell(q.pins.we_n) && !q.rb_s2 |-> q.pins.cle && busy_ok(q.pins.byte_port_out);
    endproperty
    a_busy_strobe: assert property (p_busy_strobe) else $error("Write strobe while busy");

    property p_data_wp;
        @(posedge hclk) disable iff (!hresetn || !hclk_en)
            $fell(q.pins.we_n) && !q.pins.cle && !q.pins.ale |-> q.pins.wp_n;
    endproperty
    a_data_wp: assert property (p_data_wp) else $error("Data input with protect low");

    property p_read_hiz;
        @(posedge hclk) disable iff (!hresetn || !hclk_en) !q.pins.read_strobe_n |-> !q.pins.byte_port_oe;
    endproperty
    a_read_hiz: assert property (p_read_hiz) else $error("Port driven during read");

    property p_col_step;
        @(posedge hclk) disable iff (!hresetn || !hclk_en)
            $fell(q.pins.read_strobe_n) |-> q.col == $past(q.col) + 13'h1;
    endproperty
    a_col_step: assert property (p_col_step) else $error("Column not advanced");

    property p_addr_layout;
        @(posedge hclk) disable iff (!hresetn || !hclk_en)
            $fell(q.pins.we_n) && q.pins.ale && q.kind != NCP_K_ADDR1 |->
                (q.cyc != 3'h1 || q.pins.byte_port_out[7:5] == 3'h0)
                && (q.cyc != 3'h4 || q.pins.byte_port_out[7:2] == 6'h00);
    endproperty
    a_addr_layout: assert property (p_addr_layout) else $error("Address cycle layout wrong");

    property p_we_pulse;
        @(posedge hclk) disable iff (!hresetn || !hclk_en) $fell(q.pins.we_n) |=> q.pins.we_n;
    endproperty
    a_we_pulse: assert property (p_we_pulse) else $error("Write strobe width wrong");

    property p_confirm_wait;
        @(posedge hclk) disable iff (!hresetn || !hclk_en)
            $rose(q.pins.we_n) && q.pins.cle && q.pins.byte_port_out == CMD_READ_CONFIRM
                |-> ##1 q.st == NCP_ST_WBUSY;
    endproperty
    a_confirm_wait: assert property (p_confirm_wait) else $error("No busy wait after read confirm");

    property p_rdy_quiet;
        @(posedge hclk) disable iff (!hresetn || !hclk_en)
            q.st == NCP_ST_WRDY |-> q.pins.we_n && q.pins.read_strobe_n;
    endproperty
    a_rdy_quiet: assert property (p_rdy_quiet) else $error("Strobe while waiting for ready");

    property p_whr_gap;
        @(posedge hclk) disable iff (!hresetn || !hclk_en) $rose(q.pins.we_n) |-> q.pins.read_strobe_n [*3];
    endproperty
    a_whr_gap: assert property (p_whr_gap) else $error("Read too soon after write");

    c_wait_ready: cover property (@(posedge hclk) disable iff (!hresetn) q.st == NCP_ST_WRDY ##1 q.st == NCP_ST_IDLE);
    c_read_byte: cover property (@(posedge hclk) disable iff (!hresetn) $fell(q.pins.read_strobe_n));
    c_refused: cover property (@(posedge hclk) disable iff (!hresetn) $rose(q.refused));
    c_addr5: cover property (@(posedge hclk) disable iff (!hresetn) $fell(q.pins.we_n) && q.pins.ale && q.cyc == 3'h4);

endmodule
`default_nettype wire

// ---- ncp_flash_model.sv ----
/* Flash device model on the host pins.
   Assumes ncp_host drives them and the ready line is pulled up. */
`timescale 1ns/100ps
`default_nettype none
module ncp_flash_model
    import ncp_pkg::*;
(
    // Host pins
    input wire ncp_pin_out_t po,
    // Device answers
    output var ncp_pin_in_t pi
);
    logic [7:0] cmd = 8'h00;
    logic [7:0] q = 8'h00, d;
    logic busy = 1'b0, drv = 1'b0;
    logic [39:0] adr = 40'h0; // One byte per address cycle
    int na = 0;
    logic [7:0] mem [logic [30:0]]; // Sparse array
    wire logic [30:0] k = {adr[33:16], adr[12:0]};
    // Busy ignores select and strobes
    wire logic wc = !po.ce_n && po.read_strobe_n && !busy;
    // Ready line, then port; a released port shows the inverse of the last byte
    assign pi = {!busy, drv ? q : ~q};
    // Write strobe rise latches a byte
    always @(posedge po.we_n) begin
        d = po.byte_port_out;
        if (!po.ce_n && po.cle && (wc || d inside {8'h70, 8'h71, 8'hFF})) begin
            cmd = d;
            na = 0;
            if (d inside {8'h30, 8'h35, 8'hFF, 8'h11} || po.wp_n && d inside {8'h10, 8'hD0}) begin
                busy <= #20 1'b1;
                busy <= #800 1'b0;
            end
        end else if (wc && po.ale) begin
            // Erase address starts at the page bytes
            adr[8 * (na + (cmd == 8'h60 ? 2 : 0)) +: 8] = d;
            na++;
        end else if (wc && !po.cle && po.wp_n) begin
            mem[k] = d;
            adr[12:0] = adr[12:0] + 13'h1;
        end
    end
    // Read strobe fall gives the next byte and steps the column
    always @(negedge po.read_strobe_n) begin
        if (!po.ce_n && !po.cle && !po.ale) begin
            q <= #18 (cmd inside {8'h70, 8'h71}) ? {po.wp_n, {2{!busy}}, 5'h00} :
                mem.exists(k) ? mem[k] : 8'(k[12:0] + k[30:13]);
            drv <= #18 1'b1;
            adr[12:0] = adr[12:0] + 13'h1;
        end
    end
    // Short output hold, then release
    always @(posedge po.read_strobe_n) drv <= #10 1'b0;
endmodule
`default_nettype wire

// ---- ncp_host_bench.sv ----
/* Self-checking bench for ncp_host with the flash model.
   Assumes one AHB-Lite master and a 40 MHz hclk. */
`timescale 1ns/100ps
`default_nettype none
module ncp_host_bench
    import ncp_pkg::*;
;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
    logic [12:0] col;
    logic [17:0] pg;
    logic [7:0] b;
    int failures = 0, compares = 0, seed = 36;
    logic en = 1'b1;
    ncp_pin_out_t po;
    ncp_pin_in_t pi;
    // 25 ns clock
    initial forever #12.5 hclk = ~hclk;
    ncp_host u_dut (.hclk(hclk), .hresetn(hresetn), .hclk_en(en), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pin_in(pi), .pin_out(po));
    ncp_flash_model u_flash (.po(po), .pi(pi));
    // Verdict
    task automatic results;
        if (failures == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s exp %h seen %h", nm, e, s);
        end
    endtask
    // Bounded wait for hready at a rising edge
    task automatic hs;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            results();
        end
    endtask
    // One single word transfer; read data lands in rd
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hs();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        hs();
        rd = hrdata;
    endtask
    // Operation, then poll until the engine is idle
    task automatic op(input logic [2:0] kd, input logic [7:0] v);
        int n;
        n = 0;
        bus(1'b1, REG_OP, {21'h0, kd, v});
        do begin
            bus(1'b0, REG_STATUS, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 400);
        if (n >= 400) begin
            failures++;
            results();
        end
    endtask
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        bus(1'b0, REG_CTRL, 32'h0);
        chk("ctrl", rd, 32'h0);
        bus(1'b0, REG_STATUS, 32'h0);
        chk("lastcmd", rd[23:16], 32'h0);
        bus(1'b0, 8'h3C, 32'h0);
        chk("unmapped", rd, 32'h0);
        chk("hresp", hresp, 32'h0);
        bus(1'b1, REG_CTRL, 32'h3);
        // Both status commands
        for (int i = 0; i < 2; i++) begin
            op(3'h0, i ? 8'h71 : 8'h70);
            op(3'h6, 8'h00);
            chk("status", rd[15:8], 32'hE0);
        end
        // Random places; odd passes program first
        for (int i = 0; i < 6; i++) begin
            col = 13'(($random(seed) & 32'hFFFF) % 4224);
            pg = 18'($random(seed));
            b = i[0] ? 8'($random(seed)) : 8'(col + pg);
            bus(1'b1, REG_COLUMN, 32'(col));
            bus(1'b1, REG_PAGE, 32'(pg));
            bus(1'b0, REG_INFO, 32'h0);
            chk("info", rd, {10'h0, pg[5:0], 4'h0, pg[17:6]});
            if (i[0]) begin
                op(3'h0, 8'h80);
                op(3'h1, 8'h00);
                op(3'h5, b);
                op(3'h0, 8'h10);
            end
            op(3'h0, 8'h00);
            op(3'h1, 8'h00);
            op(3'h0, 8'h30);
            op(3'h6, 8'h00);
            chk("data", rd[15:8], 32'(b));
            bus(1'b0, REG_COLUMN, 32'h0);
            chk("column", rd, 32'(col + 13'h1));
        end
        // Column past the page, then protected data write
        bus(1'b1, REG_COLUMN, 32'h1080);
        op(3'h1, 8'h00);
        chk("refcol", rd[2], 32'h1);
        bus(1'b1, REG_CTRL, 32'h1);
        op(3'h5, 8'h5A);
        chk("refwp", rd[2], 32'h1);
        // A transfer made while the enable is low must leave no trace
        bus(1'b1, REG_COLUMN, 32'h123);
        en <= 1'b0;
        bus(1'b1, REG_COLUMN, 32'h456);
        en <= 1'b1;
        bus(1'b0, REG_COLUMN, 32'h0);
        chk("frozen", rd, 32'h123);
        results();
    end
endmodule
`default_nettype wire
